// ---- src/xcvr_defines.svh ----
// Constants of the transceiver control block: register map, fields, timing.
// Assumes inclusion by bare name from the package and the design module.
`ifndef XCVR_DEFINES_SVH
`define XCVR_DEFINES_SVH

// ----------------------------------------------------------------
// Bus address and register map
// ----------------------------------------------------------------
`define DEV_ADDR7 7'h34
`define NUM_REGS 8'h20
`define REG_PORT_CTRL 8'h0c
`define REG_CLK_SRC 8'h0d
`define REG_PIN_CFG 8'h0e
`define REG_WAKE_TIMER 8'h10
`define REG_STATUS 8'h11
`define REG_MON_DRIVE 8'h1e
`define REG_RESET_VAL 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_PTR_HOLD 2
`define BIT_RX_EN 3
`define BIT_CLOCK_OUTPUT_PIN_OFF 7
`define BIT_SRC_LO 4
`define BIT_SRC_HI 5
`define BIT_DIV_LO 0
`define BIT_DIV_HI 1
`define BIT_REF_SEL 3
`define BIT_MON_DRIVE 4
`define SRC_AUTO 2'h0
`define SRC_RC 2'h1
`define SRC_XTAL 2'h2
`define SRC_OFF 2'h3
`define DIV_BY1 2'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_NS 100
`define ALERT_NS 10000
`define ALERT_CYC ((`ALERT_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ---- src/xcvr_pkg.sv ----
// Types of the transceiver control block: slave states and the state record.
// Assumes xcvr_defines.svh is reachable on the include path.
`include "xcvr_defines.svh"
`default_nettype none

package xcvr_pkg;

    // ----------------------------------------------------------------
    // Serial slave states, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_ADDR = 9'h002,
        ST_ADDR_ACK = 9'h004,
        ST_REG = 9'h008,
        ST_REG_ACK = 9'h010,
        ST_WDATA = 9'h020,
        ST_WDATA_ACK = 9'h040,
        ST_RDATA = 9'h080,
        ST_RDATA_ACK = 9'h100
    } slave_state_t;

    // Whole state of the block
    typedef struct packed {
        slave_state_t fsm;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [7:0] ptr;
        logic rw;
        logic sda_drive;
        logic scl_q;
        logic sda_q;
        logic [31:0][7:0] regs;
        logic xtal_q;
        logic [1:0] div_cnt;
        logic xdiv;
        logic clk_out;
        logic [7:0] wake_cnt;
        logic wake_pend;
        logic rx_wake;
        logic alert_req;
        logic [7:0] alert_cnt;
        logic mon_ref;
        logic mon_drive;
    } state_t;

endpackage : xcvr_pkg

`default_nettype wire

// ---- src/i2c_slave_pin_output_select.sv ----
// Control logic of the transceiver: two-wire slave register port, monitor pin
// and clock output pin selection, polling receiver wake and wake-up alert.
// Assumes bus pins and oscillator levels arrive synchronous to clk.
`include "xcvr_defines.svh"
`default_nettype none

// Function
// - Bit 3 of 0x0e routes the reference voltage to the monitor pin.
// - Bit 4 of 0x1e drives signal level onto monitor pin, else tri-state.
// - Reference appears only in receive, transmit or crystal-running mode.
// - Bit 7 of 0x0c low enables the clock output, high disables it.
// - Bits 5:4 of 0x0d pick auto, RC, crystal or off for clock output.
// - Bits 1:0 of 0x0e divide crystal clock by 4, 3, 2 or 1.
// - Recovered data clock can be driven onto the clock output pin.
// - Device is slave only; the master makes every bus clock.
// - Slave port works up to 100 and 400 kbit/s.
// - Slave answers address byte 0x68 for write, 0x69 for read.
// - Bit 2 of 0x0c low steps pointer after written byte, high holds it.
// - Register data moves as whole 8-bit bytes both ways.
// - During polling, detected RF energy switches the receiver on.
// - A wake-up timer sets status bit 0 and alerts the controller.
// - Bus data line signals wake events to the controller.
module i2c_slave_pin_output_select (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic serial_ctrl_clock_pin,
    input wire logic serial_ctrl_data_in,
    output logic serial_ctrl_data_out,
    output logic serial_ctrl_data_oe_n,
    input wire logic rx_active,
    input wire logic tx_active,
    input wire logic xtal_running,
    input wire logic cdr_mode,
    input wire logic rc_osc_in,
    input wire logic xtal_clk_in,
    input wire logic recovered_clk_in,
    input wire logic polling_active,
    input wire logic rf_energy_detect,
    input wire logic wake_tick,
    output logic reference_to_monitor,
    output logic monitor_drive_en,
    output logic clock_output_pin,
    output logic receiver_enable
);

    xcvr_pkg::state_t s;
    xcvr_pkg::state_t next_s;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic ptr_hold;
    logic [7:0] rd_byte;
    logic [7:0] status;
    logic [1:0] div_limit;
    logic [1:0] src_sel;
    logic xtal_edge;
    logic alert_on;
    logic wake_event;
    logic mode_ok;

    // ----------------------------------------------------------------
    // Bus conditions and register views
    // ----------------------------------------------------------------
    // edges and start/stop from last cycle's levels, far above bus rate
    assign scl_rise = serial_ctrl_clock_pin & ~s.scl_q;
    assign scl_fall = ~serial_ctrl_clock_pin & s.scl_q;
    assign alert_on = (s.alert_cnt != 8'h00);
    assign start_seen = s.scl_q & serial_ctrl_clock_pin & s.sda_q & ~serial_ctrl_data_in
        & ~alert_on;
    assign stop_seen = s.scl_q & serial_ctrl_clock_pin & ~s.sda_q & serial_ctrl_data_in;
    assign ptr_hold = s.regs[`REG_PORT_CTRL][`BIT_PTR_HOLD];
    assign status = {6'h00, s.rx_wake, s.wake_pend};
    assign src_sel = s.regs[`REG_CLK_SRC][`BIT_SRC_HI:`BIT_SRC_LO];
    assign xtal_edge = xtal_clk_in ^ s.xtal_q;
    assign mode_ok = rx_active | tx_active | xtal_running;

    // Read data: live status, stored register, or zero outside the map
    always_comb begin
        if (s.ptr == `REG_STATUS) begin
            rd_byte = status;
        end else if (s.ptr < `NUM_REGS) begin
            rd_byte = s.regs[s.ptr[4:0]];
        end else begin
            rd_byte = 8'h00;
        end
    end

    always_comb begin
        case (s.regs[`REG_PIN_CFG][`BIT_DIV_HI:`BIT_DIV_LO])
            2'h0: div_limit = 2'h3;
            2'h1: div_limit = 2'h2;
            2'h2: div_limit = 2'h1;
            default: div_limit = 2'h0;
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        wake_event = 1'b0;
        next_s.scl_q = serial_ctrl_clock_pin;
        next_s.sda_q = serial_ctrl_data_in;
        // slave only: every step follows master clock edges
        if (stop_seen) begin
            next_s.fsm = xcvr_pkg::ST_IDLE;
            next_s.sda_drive = 1'b0;
        end else if (start_seen) begin
            next_s.fsm = xcvr_pkg::ST_ADDR;
            next_s.bit_cnt = 4'h0;
            next_s.sda_drive = 1'b0;
        end else begin
            case (s.fsm)
                xcvr_pkg::ST_ADDR, xcvr_pkg::ST_REG, xcvr_pkg::ST_WDATA: begin
                    // whole bytes shifted in, msb first
                    if (scl_rise) begin
                        next_s.shift = {s.shift[6:0], serial_ctrl_data_in};
                        next_s.bit_cnt = 4'(s.bit_cnt + 4'h1);
                    end else if (scl_fall && s.bit_cnt == 4'h8) begin
                        next_s.sda_drive = 1'b1;
                        if (s.fsm == xcvr_pkg::ST_ADDR) begin
                            if (s.shift[7:1] == `DEV_ADDR7) begin
                                next_s.rw = s.shift[0];
                                next_s.fsm = xcvr_pkg::ST_ADDR_ACK;
                            end else begin
                                next_s.sda_drive = 1'b0;
                                next_s.fsm = xcvr_pkg::ST_IDLE;
                            end
                        end else if (s.fsm == xcvr_pkg::ST_REG) begin
                            next_s.ptr = s.shift;
                            next_s.fsm = xcvr_pkg::ST_REG_ACK;
                        end else begin
                            if (s.ptr < `NUM_REGS && s.ptr != `REG_STATUS) begin
                                next_s.regs[s.ptr[4:0]] = s.shift;
                            end
                            if (!ptr_hold) begin
                                next_s.ptr = 8'(s.ptr + 8'h01);
                            end
                            next_s.fsm = xcvr_pkg::ST_WDATA_ACK;
                        end
                    end
                end
                xcvr_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        next_s.bit_cnt = 4'h0;
                        if (s.rw) begin
                            next_s.fsm = xcvr_pkg::ST_RDATA;
                            next_s.shift = rd_byte;
                            next_s.sda_drive = ~rd_byte[7];
                            if (s.ptr == `REG_STATUS) begin
                                next_s.wake_pend = 1'b0;
                            end
                        end else begin
                            next_s.fsm = xcvr_pkg::ST_REG;
                            next_s.sda_drive = 1'b0;
                        end
                    end
                end
                xcvr_pkg::ST_REG_ACK, xcvr_pkg::ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        next_s.bit_cnt = 4'h0;
                        next_s.sda_drive = 1'b0;
                        next_s.fsm = xcvr_pkg::ST_WDATA;
                    end
                end
                xcvr_pkg::ST_RDATA: begin
                    // whole bytes shifted out, msb first
                    if (scl_fall) begin
                        next_s.bit_cnt = 4'(s.bit_cnt + 4'h1);
                        if (s.bit_cnt == 4'h7) begin
                            next_s.sda_drive = 1'b0;
                            next_s.fsm = xcvr_pkg::ST_RDATA_ACK;
                        end else begin
                            next_s.shift = {s.shift[6:0], 1'b0};
                            next_s.sda_drive = ~s.shift[6];
                        end
                    end
                end
                xcvr_pkg::ST_RDATA_ACK: begin
                    // Master acknowledge asks for another byte
                    if (scl_rise) begin
                        if (serial_ctrl_data_in) begin
                            next_s.fsm = xcvr_pkg::ST_IDLE;
                        end else begin
                            next_s.bit_cnt = 4'h8;
                        end
                    end else if (scl_fall && s.bit_cnt == 4'h8) begin
                        next_s.bit_cnt = 4'h0;
                        next_s.shift = rd_byte;
                        next_s.sda_drive = ~rd_byte[7];
                        next_s.fsm = xcvr_pkg::ST_RDATA;
                        if (s.ptr == `REG_STATUS) begin
                            next_s.wake_pend = 1'b0;
                        end
                    end
                end
                default: begin
                    next_s.sda_drive = 1'b0;
                end
            endcase
        end
        // reference only while the analog core runs
        next_s.mon_ref = s.regs[`REG_PIN_CFG][`BIT_REF_SEL] & mode_ok;
        next_s.mon_drive = s.regs[`REG_MON_DRIVE][`BIT_MON_DRIVE];
        // crystal divider, toggling every N crystal half periods
        next_s.xtal_q = xtal_clk_in;
        if (xtal_edge) begin
            if (s.div_cnt >= div_limit) begin
                next_s.div_cnt = 2'h0;
                next_s.xdiv = ~s.xdiv;
            end else begin
                next_s.div_cnt = 2'(s.div_cnt + 2'h1);
            end
        end
        if (s.regs[`REG_PORT_CTRL][`BIT_CLOCK_OUTPUT_PIN_OFF] || src_sel == `SRC_OFF) begin
            next_s.clk_out = 1'b0;
        end else if (src_sel == `SRC_RC) begin
            next_s.clk_out = rc_osc_in;
        end else if (src_sel == `SRC_AUTO && cdr_mode) begin
            next_s.clk_out = recovered_clk_in;
        end else if (src_sel == `SRC_AUTO && !xtal_running) begin
            next_s.clk_out = rc_osc_in;
        end else if (div_limit == 2'h0) begin
            next_s.clk_out = xtal_clk_in;
        end else begin
            next_s.clk_out = s.xdiv;
        end
        // receiver wake on RF energy while polling
        if (polling_active && rf_energy_detect) begin
            wake_event = ~s.rx_wake;
            next_s.rx_wake = 1'b1;
        end else if (!polling_active) begin
            next_s.rx_wake = 1'b0;
        end
        // wake-up timer counts slow ticks, reloads on expiry
        if (s.regs[`REG_WAKE_TIMER] == 8'h00) begin
            next_s.wake_cnt = 8'h00;
        end else if (wake_tick) begin
            if (s.wake_cnt <= 8'h01) begin
                next_s.wake_cnt = s.regs[`REG_WAKE_TIMER];
                next_s.wake_pend = 1'b1;
                wake_event = 1'b1;
            end else begin
                next_s.wake_cnt = 8'(s.wake_cnt - 8'h01);
            end
        end
        // alert pulse on the data line while the bus is idle
        if (alert_on) begin
            next_s.alert_cnt = 8'(s.alert_cnt - 8'h01);
        end else if (s.alert_req && s.fsm == xcvr_pkg::ST_IDLE && s.scl_q && s.sda_q) begin
            next_s.alert_cnt = 8'(`ALERT_CYC);
            next_s.alert_req = 1'b0;
        end
        if (wake_event) begin
            next_s.alert_req = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{fsm: xcvr_pkg::ST_IDLE, scl_q: 1'b1, sda_q: 1'b1, default: '0};
        end else begin
            s <= next_s;
        end
    end

    // Outputs
    assign serial_ctrl_data_out = 1'b0;
    assign serial_ctrl_data_oe_n = ~(s.sda_drive | alert_on);
    assign reference_to_monitor = s.mon_ref;
    assign monitor_drive_en = s.mon_drive;
    assign clock_output_pin = s.clk_out;
    assign receiver_enable = s.regs[`REG_PORT_CTRL][`BIT_RX_EN] | s.rx_wake;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_ref_needs_mode: assert property (
        reference_to_monitor |-> $past(mode_ok))
        else $error("reference shown outside run modes");
    chk_ref_select: assert property (
        reference_to_monitor |-> $past(s.regs[`REG_PIN_CFG][`BIT_REF_SEL]))
        else $error("reference shown without selection");
    chk_monitor_drive: assert property (
        $changed(s.regs[`REG_MON_DRIVE][`BIT_MON_DRIVE]) |=>
        monitor_drive_en == $past(s.regs[`REG_MON_DRIVE][`BIT_MON_DRIVE]))
        else $error("monitor driver not following config");
    chk_clock_output_pin_gate: assert property (
        s.regs[`REG_PORT_CTRL][`BIT_CLOCK_OUTPUT_PIN_OFF] [*2] |-> !clock_output_pin)
        else $error("clock output active while disabled");
    chk_clock_output_pin_off_sel: assert property (
        src_sel == `SRC_OFF |=> !clock_output_pin)
        else $error("clock output active with source off");
    chk_xtal_passthru: assert property (
        (src_sel == `SRC_XTAL && div_limit == 2'h0
        && !s.regs[`REG_PORT_CTRL][`BIT_CLOCK_OUTPUT_PIN_OFF]) |=> clock_output_pin == $past(xtal_clk_in))
        else $error("undivided crystal not passed");
    chk_cdr_route: assert property (
        (src_sel == `SRC_AUTO && cdr_mode && !s.regs[`REG_PORT_CTRL][`BIT_CLOCK_OUTPUT_PIN_OFF])
        |=> clock_output_pin == $past(recovered_clk_in))
        else $error("recovered clock not routed");
    chk_addr_ack: assert property (
        (s.fsm == xcvr_pkg::ST_ADDR && scl_fall && s.bit_cnt == 4'h8 && !stop_seen
        && !start_seen && s.shift[7:1] == `DEV_ADDR7) |=> !serial_ctrl_data_oe_n
        && s.fsm == xcvr_pkg::ST_ADDR_ACK)
        else $error("own address not acknowledged");
    chk_ptr_step: assert property (
        (s.fsm == xcvr_pkg::ST_WDATA && scl_fall && s.bit_cnt == 4'h8 && !stop_seen
        && !start_seen) |=> s.ptr == ($past(ptr_hold) ? $past(s.ptr) : 8'($past(s.ptr) + 8'h01)))
        else $error("pointer step wrong after write");
    chk_rf_wake: assert property (
        (polling_active && rf_energy_detect) |=> receiver_enable)
        else $error("receiver not woken by RF energy");
    chk_alert_pulse: assert property (
        $rose(alert_on) |-> !serial_ctrl_data_oe_n ##1 alert_on)
        else $error("alert pulse not held on data line");

    cov_write_byte: cover property (s.fsm == xcvr_pkg::ST_WDATA_ACK);
    cov_read_byte: cover property (s.fsm == xcvr_pkg::ST_RDATA_ACK);
    cov_wake_alert: cover property ($rose(alert_on));
    cov_ref_shown: cover property (reference_to_monitor);

endmodule : i2c_slave_pin_output_select

`default_nettype wire

// ---- bench/i2c_master_model.sv ----
// Bus master model that drives the slave's two-wire control port.
// Assumes the bench calls its tasks and that both bus lines have pull-ups.
`default_nettype none
module i2c_master_model (
    input wire logic clk,
    input wire logic data_out,
    input wire logic data_oe_n,
    output logic bus_clk,
    output logic bus_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic m_data = 1'b1;
    // Wait cycles per half level, plus 2 more; 11 gives under 400 kbit/s, 48 gives 100 kbit/s
    int q = 11;
    // Wired data line: pull-up wins unless a party pulls it low
    assign bus_data = m_data & (data_oe_n | data_out);
    initial bus_clk = 1'b1;
    // Clock moves first, data two cycles later, so data never moves with a clock edge
    task automatic step(input logic c, input logic d);
        repeat (q) @(posedge clk);
        #5;
        bus_clk = c;
        repeat (2) @(posedge clk);
        #5;
        m_data = d;
    endtask : step
    task automatic start();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask : start
    task automatic stop();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask : stop
    // Sends a byte msb first and returns the acknowledge level
    task automatic wbyte(input logic [7:0] b, output logic a);
        for (int i = 7; i >= 0; i--) begin
            step(1'b0, b[i]);
            step(1'b1, b[i]);
        end
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        a = bus_data;
    endtask : wbyte
    // Reads a byte msb first, then answers with m_ack
    task automatic rbyte(input logic m_ack, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            step(1'b0, 1'b1);
            step(1'b1, 1'b1);
            b[i] = bus_data;
        end
        step(1'b0, m_ack);
        step(1'b1, m_ack);
    endtask : rbyte
endmodule : i2c_master_model
`default_nettype wire

// ---- bench/i2c_slave_pin_output_select_bench.sv ----
// Self-checking bench of the slave register port and the pin selection.
// Assumes the master model and the design sources are compiled first.
`default_nettype none
module i2c_slave_pin_output_select_bench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        string nm;
        logic [7:0] exp;
    } note_t;
    note_t notes[$];
    note_t n;
    event seen_ev;
    logic [7:0] seen, b, d;
    logic a, clk = 1'b0, rst_n = 1'b0;
    int error_cnt = 0, compares = 0, seed = 62, low_run = 0, last_low = 0;
    logic rx_active, tx_active, xtal_running, cdr_mode, rc_osc_in, xtal_clk_in, xt_run;
    logic recovered_clk_in, polling_active, rf_energy_detect, wake_tick;
    logic bus_clk, bus_data, data_out, data_oe_n, reference_to_monitor, monitor_drive_en;
    logic clock_output_pin, receiver_enable;

    // ----------------------------------------------------------------
    // Clock, model, design and watchers
    // ----------------------------------------------------------------
    always #50 clk = ~clk;
    i2c_master_model i_mst (.clk(clk), .data_out(data_out), .data_oe_n(data_oe_n),
        .bus_clk(bus_clk), .bus_data(bus_data));
    i2c_slave_pin_output_select i_dut (.clk(clk), .rst_n(rst_n),
        .serial_ctrl_clock_pin(bus_clk), .serial_ctrl_data_in(bus_data),
        .serial_ctrl_data_out(data_out), .serial_ctrl_data_oe_n(data_oe_n),
        .rx_active(rx_active), .tx_active(tx_active), .xtal_running(xtal_running),
        .cdr_mode(cdr_mode), .rc_osc_in(rc_osc_in), .xtal_clk_in(xtal_clk_in),
        .recovered_clk_in(recovered_clk_in), .polling_active(polling_active),
        .rf_energy_detect(rf_energy_detect), .wake_tick(wake_tick),
        .reference_to_monitor(reference_to_monitor), .monitor_drive_en(monitor_drive_en),
        .clock_output_pin(clock_output_pin), .receiver_enable(receiver_enable));
    // Length of the latest low pulse on the data enable
    always @(posedge clk) begin
        if (data_oe_n === 1'b0) low_run <= low_run + 1;
        else if (low_run != 0) begin
            last_low <= low_run;
            low_run <= 0;
        end
    end
    // Crystal level toggles every second cycle while running
    always begin
        tick(2);
        if (xt_run) xtal_clk_in = ~xtal_clk_in;
    end
    // Oldest note is compared with each result as it appears
    always begin
        @(seen_ev);
        n = notes.pop_front();
        check(n.nm, n.exp, seen);
    end
    initial begin
        #6000000;
        error_cnt++;
        test_done();
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #5;
    endtask : tick
    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] v);
        compares++;
        if (v !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, e, v);
        end
    endtask : check
    task automatic obs(input string nm, input logic [7:0] e, input logic [7:0] v);
        notes.push_back('{nm, e});
        seen = v;
        ->seen_ev;
        #1;
    endtask : obs
    task automatic wr(input logic [7:0] idx, input int cnt, input logic [7:0] d0,
        input logic [7:0] d1);
        logic ak;
        i_mst.start();
        i_mst.wbyte(8'h68, ak);
        obs("ack write addr", 8'h00, {7'h00, ak});
        i_mst.wbyte(idx, ak);
        i_mst.wbyte(d0, ak);
        if (cnt > 1) i_mst.wbyte(d1, ak);
        obs("ack data", 8'h00, {7'h00, ak});
        i_mst.stop();
    endtask : wr
    task automatic rd(input logic [7:0] idx, input logic [7:0] e1, input logic [7:0] e2,
        input string nm);
        logic ak;
        logic [7:0] v;
        i_mst.start();
        i_mst.wbyte(8'h68, ak);
        i_mst.wbyte(idx, ak);
        i_mst.start();
        i_mst.wbyte(8'h69, ak);
        obs("ack read addr", 8'h00, {7'h00, ak});
        i_mst.rbyte(1'b0, v);
        obs(nm, e1, v);
        i_mst.rbyte(1'b1, v);
        obs(nm, e2, v);
        i_mst.stop();
    endtask : rd
    task automatic lvl(input string nm, input logic e);
        tick(2);
        obs(nm, {7'h00, e}, {7'h00, clock_output_pin});
    endtask : lvl
    // Cycles between two output changes, after one settling change
    task automatic toggle(input logic [7:0] e, input string nm);
        logic p;
        int c;
        for (int k = 0; k < 3; k++) begin
            p = clock_output_pin;
            for (c = 0; c < 40 && clock_output_pin === p; c++) tick(1);
        end
        obs(nm, e, 8'(c));
    endtask : toggle
    task automatic test_done();
        if (error_cnt == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    // Main sequence
    initial begin
        {rx_active, tx_active, xtal_running, cdr_mode, rc_osc_in, xtal_clk_in} = 6'h00;
        {recovered_clk_in, polling_active, rf_energy_detect, wake_tick, xt_run} = 5'h00;
        tick(6);
        rst_n = 1'b1;
        tick(2);
        obs("reset pins", 8'h01, {5'h00, monitor_drive_en, reference_to_monitor, data_oe_n});
        b = 8'($random(seed));
        if (b[7:1] == 7'h34) b[6] = ~b[6];
        i_mst.start();
        i_mst.wbyte(b, a);
        obs("ack wrong addr", 8'h01, {7'h00, a});
        i_mst.stop();
        b = (8'($random(seed)) & 8'hcf) | 8'h20;
        d = 8'($random(seed)) & 8'hf7;
        wr(8'h0d, 2, b, d);
        rd(8'h0d, b, b, "reg 0d");
        rd(8'h0e, d, d, "reg 0e stepped");
        wr(8'h0c, 1, 8'h04, 8'h00);
        d = 8'($random(seed)) | 8'h10;
        wr(8'h1e, 2, ~d, d);
        rd(8'h1e, d, d, "reg 1e held");
        rd(8'h1f, 8'h00, 8'h00, "reg 1f");
        obs("drive en", 8'h01, {7'h00, monitor_drive_en});
        xt_run = 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(8'h0e, 1, 8'(i), 8'h00);
            toggle(8'(8 - 2 * i), "xtal divide");
        end
        wr(8'h0d, 1, 8'h10, 8'h00);
        for (int i = 0; i < 4; i++) begin
            rc_osc_in = 1'($random(seed));
            lvl("rc source", rc_osc_in);
        end
        wr(8'h0d, 1, 8'h30, 8'h00);
        lvl("off source", 1'b0);
        rc_osc_in = 1'b1;
        wr(8'h0d, 1, 8'h00, 8'h00);
        lvl("auto rc", 1'b1);
        cdr_mode = 1'b1;
        for (int i = 0; i < 4; i++) begin
            recovered_clk_in = 1'($random(seed));
            lvl("auto recovered", recovered_clk_in);
        end
        recovered_clk_in = 1'b1;
        wr(8'h0c, 1, 8'h84, 8'h00);
        lvl("gated output", 1'b0);
        wr(8'h0c, 1, 8'h04, 8'h00);
        cdr_mode = 1'b0;
        wr(8'h0e, 1, 8'h08, 8'h00);
        for (int i = 0; i < 8; i++) begin
            {rx_active, tx_active, xtal_running} = 3'(i);
            tick(2);
            obs("reference", {7'h00, i != 0}, {7'h00, reference_to_monitor});
        end
        toggle(8'h08, "auto xtal");
        wr(8'h0e, 1, 8'h00, 8'h00);
        obs("reference off", 8'h00, {7'h00, reference_to_monitor});
        wr(8'h1e, 1, 8'h00, 8'h00);
        obs("drive off", 8'h00, {7'h00, monitor_drive_en});
        polling_active = 1'b1;
        rf_energy_detect = 1'b1;
        tick(3);
        rf_energy_detect = 1'b0;
        tick(2);
        obs("rf wake", 8'h01, {7'h00, receiver_enable});
        polling_active = 1'b0;
        tick(150);
        obs("rf alert", 8'h64, 8'(last_low));
        obs("rf wake end", 8'h00, {7'h00, receiver_enable});
        wr(8'h10, 1, 8'h02, 8'h00);
        repeat (2) begin
            tick(3);
            wake_tick = 1'b1;
            tick(1);
            wake_tick = 1'b0;
        end
        tick(150);
        obs("timer alert", 8'h64, 8'(last_low));
        i_mst.q = 48;
        rd(8'h11, 8'h01, 8'h00, "status slow");
        tick(4);
        test_done();
    end
endmodule : i2c_slave_pin_output_select_bench
`default_nettype wire
